// File: dv/tcam_alarm_monitor_chk.sv
`timescale 1ns/1ns
`default_nettype none
module tcam_alarm_monitor_chk import tcam_pkg::*; #(
  parameter int unsigned AIS_PERIOD   = AIS_PERIOD_BITS,
  parameter int unsigned AIS_DECLARE  = AIS_DECLARE_PER,
  parameter int unsigned RAI_LOSS_CYC = tcam_pkg::RAI_LOSS_CYC
) (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [2:0]            hsize,
  input wire logic [31:0]           hwdata,
  input wire logic                  hready,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic [31:0]           hrdata,
  input wire logic                  lineBit,
  input wire logic                  lineBitEn,
  input wire logic                  fdlBit,
  input wire logic                  fdlBitEn,
  input wire tcam_pkg::tcam_alarm_t alarmPresent,
  input wire logic                  irq
);
  logic        acc;
  logic        rdSt;
  logic        wrPh;
  logic [15:0] wrAd;
  logic [2:0]  cfgSh;
  logic [1:0]  ienSh;
  assign acc = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD
               && haddr[31:16] == 16'h0000;
  assign rdSt = acc && !hwrite && haddr[15:0] == STATUS_ADDR;
  // Shadows rebuilt from bus traffic alone, so no design internals are needed
  always_ff @(posedge sys_clk) begin
    wrAd <= haddr[15:0];
    if (rst) begin
      wrPh  <= 1'b0;
      cfgSh <= 3'h0;
      ienSh <= 2'h0;
    end else begin
      wrPh <= acc && hwrite;
      if (wrPh && wrAd == CFG_ADDR) cfgSh <= hwdata[2:0];
      if (wrPh && wrAd == IRQEN_ADDR) ienSh <= hwdata[1:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_bus_ok; hreadyout && !hresp; endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready and okay");
  property p_ais_gate; (!cfgSh[0]) [*6] |-> !alarmPresent.aisPresent; endproperty
  a_ais_gate: assert property (p_ais_gate) else $error("indication while off");
  property p_rai_gate; (!(cfgSh[1] && cfgSh[2])) [*6] |-> !alarmPresent.raiPresent; endproperty
  a_rai_gate: assert property (p_rai_gate) else $error("remote alarm while off");
  property p_rd_resv; rdSt |=> hrdata[31:6] == 26'h0 && hrdata[3:2] == 2'h0; endproperty
  a_rd_resv: assert property (p_rd_resv) else $error("reserved status bits set");
  property p_unmap; acc && !hwrite && haddr == 32'h0000_0100 |=> hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_rd_pres; rdSt |=> hrdata[5:4] == alarmPresent; endproperty
  a_rd_pres: assert property (p_rd_pres) else $error("present bits mismatch");
  property p_irq_gate; irq |-> $past(ienSh) != 2'h0; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
  property p_rd_hold; !(acc && !hwrite) |=> $stable(hrdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule : tcam_alarm_monitor_chk
bind tcam_alarm_monitor tcam_alarm_monitor_chk #(.AIS_PERIOD(AIS_PERIOD),
  .AIS_DECLARE(AIS_DECLARE), .RAI_LOSS_CYC(RAI_LOSS_CYC)) i_chk (.sys_clk(sys_clk),
  .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .lineBit(lineBit), .lineBitEn(lineBitEn), .fdlBit(fdlBit), .fdlBitEn(fdlBitEn),
  .alarmPresent(alarmPresent), .irq(irq));
`default_nettype wire

// File: dv/tcam_line_model.sv
`timescale 1ns/1ns
`default_nettype none
module tcam_line_model import tcam_pkg::*; (
  input  wire logic sys_clk,
  input  wire logic aisOn,
  input  wire logic raiOn,
  output var  logic lineBit,
  output var  logic lineBitEn,
  output var  logic fdlBit,
  output var  logic fdlBitEn
);
  logic       ph;
  logic [8:0] bitCnt;
  logic [6:0] fdlCnt;
  initial begin
    ph = 0; bitCnt = 0; fdlCnt = 0;
    lineBit = 0; lineBitEn = 0; fdlBit = 0; fdlBitEn = 0;
  end
  // One bit every second cycle; between bits the data lines toggle so nothing stale reads valid
  always @(posedge sys_clk) begin
    ph        <= ~ph;
    lineBitEn <= ph;
    fdlBitEn  <= ph;
    if (ph) begin
      bitCnt  <= (bitCnt == 9'h181) ? 9'h000 : bitCnt + 9'h001;
      fdlCnt  <= fdlCnt + 7'h01;
      lineBit <= aisOn ? (bitCnt < 9'h010 ? AIS_SIGNATURE[bitCnt[3:0]] : 1'b1) : bitCnt[0];
      // Six message words, then two signature words, per repeat
      fdlBit  <= raiOn ? (fdlCnt[6:5] == 2'b11 ? RAI_SIGNATURE[fdlCnt[3:0]]
                                               : RAI_MESSAGE[fdlCnt[3:0]]) : ~fdlBit;
    end else begin
      lineBit <= ~lineBit;
      fdlBit  <= ~fdlBit;
    end
  end
endmodule : tcam_line_model
`default_nettype wire

// File: dv/test_t1_ci_alarm_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module test_t1_ci_alarm_monitor;
  import tcam_pkg::*;
  localparam int unsigned LOSS = 2000;
  logic        sys_clk, rst, hsel, hwrite, hreadyout, hresp, irq, aisOn, raiOn;
  logic        lineBit, lineBitEn, fdlBit, fdlBitEn;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  tcam_alarm_t alarmPresent;
  int          failures, cmp_count, expAis, expRai, chgA, chgR;
  tcam_alarm_monitor #(.RAI_LOSS_CYC(LOSS)) i_dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .lineBit(lineBit), .lineBitEn(lineBitEn), .fdlBit(fdlBit), .fdlBitEn(fdlBitEn),
    .alarmPresent(alarmPresent), .irq(irq));
  tcam_line_model i_line (.sys_clk(sys_clk), .aisOn(aisOn), .raiOn(raiOn), .lineBit(lineBit),
    .lineBitEn(lineBitEn), .fdlBit(fdlBit), .fdlBitEn(fdlBitEn));
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic tmo();
    failures++;
    $display("ERROR %0t wait timed out", $time);
    end_of_test();
  endtask : tmo
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic hs();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      if (++n > 50) tmo();
    end while (hreadyout !== 1'b1);
  endtask : hs
  task automatic bus(input logic [15:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {16'h0000, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    hs();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hs();
    r = hrdata;
  endtask : bus
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(r, e);
  endtask : rd
  // Status read also clears the model's change bits, as the register does
  task automatic rdSt();
    rd(STATUS_ADDR, 32'(expAis * 32 + expRai * 16 + chgA * 2 + chgR));
    chgA = 0;
    chgR = 0;
  endtask : rdSt
  task automatic waitAp(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (alarmPresent[b] !== v) begin
      @(posedge sys_clk);
      if (++n > lim) tmo();
    end
    repeat (3) @(posedge sys_clk);
  endtask : waitAp
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    rst = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = HSIZE_WORD; hwdata = 0;
    aisOn = 0; raiOn = 0; failures = 0; cmp_count = 0; expAis = 0; expRai = 0; chgA = 0; chgR = 0;
    r = $urandom(2);
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(CFG_ADDR, 32'h0);
    rd(IRQEN_ADDR, 32'h0);
    rdSt();
    rd(16'h0100, 32'h0);
    bus(IRQEN_ADDR, 1'b1, $urandom);
    rd(IRQEN_ADDR, hwdata & 32'h3);
    bus(CFG_ADDR, 1'b1, $urandom);
    rd(CFG_ADDR, hwdata & 32'h7);
    bus(CFG_ADDR, 1'b1, 32'h0);
    bus(IRQEN_ADDR, 1'b1, 32'h0);
    // A byte-sized write must leave the register alone
    hsize <= 3'h0;
    bus(CFG_ADDR, 1'b1, 32'h7);
    hsize <= HSIZE_WORD;
    rd(CFG_ADDR, 32'h0);
    $display("test registers done");
    aisOn <= 1'b1;
    raiOn <= 1'b1;
    repeat (3000) @(posedge sys_clk);
    chk({30'h0, alarmPresent}, 32'h0);
    rdSt();
    bus(CFG_ADDR, 1'b1, 32'h1);
    waitAp(1, 1'b1, 5000);
    expAis = 1;
    chgA = 1;
    chk({31'h0, irq}, 32'h0);
    rdSt();
    rdSt();
    bus(STATUS_ADDR, 1'b1, 32'hFF);
    rdSt();
    $display("test indication set done");
    bus(IRQEN_ADDR, 1'b1, 32'h2);
    aisOn <= 1'b0;
    waitAp(1, 1'b0, 2000);
    expAis = 0;
    chgA = 1;
    chk({31'h0, irq}, 32'h1);
    rdSt();
    repeat (3) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    $display("test indication clear done");
    bus(CFG_ADDR, 1'b1, 32'h3);
    repeat (1500) @(posedge sys_clk);
    rdSt();
    bus(IRQEN_ADDR, 1'b1, 32'h1);
    bus(CFG_ADDR, 1'b1, 32'h7);
    waitAp(0, 1'b1, 1500);
    expRai = 1;
    chgR = 1;
    chk({31'h0, irq}, 32'h1);
    rdSt();
    raiOn <= 1'b0;
    waitAp(0, 1'b0, LOSS + 600);
    expRai = 0;
    chgR = 1;
    rdSt();
    $display("test remote alarm done");
    end_of_test();
  end
endmodule : test_t1_ci_alarm_monitor
`default_nettype wire

// File: rtl/tcam_ais_detect.sv
`timescale 1ns/1ns
`default_nettype none
module tcam_ais_detect #(
  parameter int unsigned PERIOD  = tcam_pkg::AIS_PERIOD_BITS,
  parameter int unsigned DECLARE = tcam_pkg::AIS_DECLARE_PER
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic lineBit,
  input  wire logic lineBitEn,
  output var  logic present
);
  import tcam_pkg::*;

  logic [15:0] shift_r;
  logic [9:0]  gap_r;
  logic [3:0]  zeros_r;
  logic [2:0]  good_r;
  logic [15:0] shift_nxt;
  logic [9:0]  gap_nxt;
  logic [3:0]  zeros_nxt;

  always_comb begin
    shift_nxt = {lineBit, shift_r[15:1]};
    gap_nxt   = gap_r + 10'h001;
    zeros_nxt = (zeros_r == 4'hF) ? zeros_r : zeros_r + {3'h0, ~lineBit};
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !enable) begin
      shift_r <= 16'hFFFF;
      gap_r   <= 10'h000;
      zeros_r <= 4'h0;
      good_r  <= 3'h0;
    end else if (lineBitEn) begin
      shift_r <= shift_nxt;
      if (shift_nxt == AIS_SIGNATURE) begin // [R2]
        // Spacing counted end to end; ones only elsewhere in the period
        if (gap_nxt == PERIOD[9:0] && zeros_nxt <= AIS_SIG_ZEROS[3:0]) begin // [R2]
          good_r <= (good_r == 3'h7) ? good_r : good_r + 3'h1;
        end else begin
          good_r <= 3'h1;
        end
        gap_r   <= 10'h000;
        zeros_r <= 4'h0;
      end else if (gap_nxt > PERIOD[9:0]) begin
        good_r  <= 3'h0; // [R9]
        gap_r   <= 10'h000;
        zeros_r <= 4'h0;
      end else begin
        gap_r   <= gap_nxt;
        zeros_r <= zeros_nxt;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      present <= 1'b0;
    end else begin
      present <= enable && (good_r >= DECLARE[2:0]); // [R6] [R9]
    end
  end

endmodule : tcam_ais_detect
`default_nettype wire

// File: rtl/tcam_alarm_monitor.sv
// How it works
// [R1] Status bit 5 is read-only and shows alarm indication signature currently detected.
// [R2] Alarm indication is all ones with signature 7CFF, LSB first, every 386 bits.
// [R3] Status bit 4 is read-only remote alarm state, detected only in ESF framing.
// [R4] Remote alarm repeats every 1.08 s, starting with 0.99 s of message 00FF.
// [R5] Rest of period is a 90 ms signature burst; matching it declares remote alarm.
// [R6] Present bits stay zero unless detection is enabled in configuration register 0x011C.
// [R7] Bits 1 and 0 latch any change of either alarm; reading clears them.
// [R8] Interrupt enable register, reset zero, gates each latched change onto the interrupt.
// [R9] Present bits drop when matching stops; bits 7:6 and 3:2 read zero.
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module tcam_alarm_monitor #(
  parameter int unsigned AIS_PERIOD   = tcam_pkg::AIS_PERIOD_BITS,
  parameter int unsigned AIS_DECLARE  = tcam_pkg::AIS_DECLARE_PER,
  parameter int unsigned RAI_LOSS_CYC = tcam_pkg::RAI_LOSS_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  input  wire logic        lineBit,
  input  wire logic        lineBitEn,
  input  wire logic        fdlBit,
  input  wire logic        fdlBitEn,
  output var  tcam_pkg::tcam_alarm_t alarmPresent,
  output var  logic        irq
);
  import tcam_pkg::*;

  typedef enum logic [3:0] {
    TCAM_REG_NONE   = 4'h1,
    TCAM_REG_CFG    = 4'h2,
    TCAM_REG_STATUS = 4'h4,
    TCAM_REG_IRQEN  = 4'h8
  } tcam_sel_t;

  tcam_req_t   req_r;
  logic [2:0]  cfg_r;
  logic [1:0]  irqEn_r;
  logic [1:0]  chg_r;
  logic [1:0]  chg_nxt;
  tcam_alarm_t det;
  tcam_alarm_t prev_r;
  logic [31:0] hrdata_r;
  logic        irq_r;
  logic        addrPhase;
  logic        readClr;
  logic        wrStatus;
  logic        wrCfg;
  logic        wrIrqEn;
  logic [1:0]  events;
  logic        aisEnable;
  logic        raiEnable;

  // Decode a word address; used for both the read and the write phase
  function automatic tcam_sel_t regDecode(input logic [15:0] addr);
    tcam_sel_t sel;
    sel = TCAM_REG_NONE;
    if (addr == CFG_ADDR) begin
      sel = TCAM_REG_CFG;
    end else if (addr == STATUS_ADDR) begin
      sel = TCAM_REG_STATUS;
    end else if (addr == IRQEN_ADDR) begin
      sel = TCAM_REG_IRQEN;
    end
    return sel;
  endfunction : regDecode

  // Only whole-word transfers act; others complete OKAY and do nothing
  assign addrPhase = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD
                     && haddr[31:16] == 16'h0000;

  assign aisEnable = cfg_r[CFG_AIS_EN_BIT]; // [R6]
  assign raiEnable = cfg_r[CFG_RAI_EN_BIT] && cfg_r[CFG_ESF_BIT]; // [R3] [R6]

  tcam_ais_detect #(
    .PERIOD  (AIS_PERIOD),
    .DECLARE (AIS_DECLARE)
  ) u_ais (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .enable    (aisEnable),
    .lineBit   (lineBit),
    .lineBitEn (lineBitEn),
    .present   (det.aisPresent)
  );

  tcam_rai_detect #(
    .LOSS_CYC (RAI_LOSS_CYC)
  ) u_rai (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .enable   (raiEnable),
    .fdlBit   (fdlBit),
    .fdlBitEn (fdlBitEn),
    .present  (det.raiPresent)
  );

  // Bus address phase captured for the data phase
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      req_r <= '0;
    end else if (hready) begin
      req_r.valid <= addrPhase;
      req_r.write <= hwrite;
      req_r.addr  <= haddr[15:0];
    end
  end

  assign wrCfg    = req_r.valid && req_r.write && regDecode(req_r.addr) == TCAM_REG_CFG;
  assign wrStatus = req_r.valid && req_r.write && regDecode(req_r.addr) == TCAM_REG_STATUS;
  assign wrIrqEn  = req_r.valid && req_r.write && regDecode(req_r.addr) == TCAM_REG_IRQEN;
  assign readClr  = addrPhase && !hwrite && regDecode(haddr[15:0]) == TCAM_REG_STATUS;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_r <= CFG_RESET[2:0];
    end else if (wrCfg) begin
      cfg_r <= hwdata[2:0] & CFG_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irqEn_r <= IRQEN_RESET[1:0]; // [R8]
    end else if (wrIrqEn) begin
      irqEn_r[IEN_AIS_BIT] <= hwdata[IEN_AIS_BIT]; // [R8]
      irqEn_r[IEN_RAI_BIT] <= hwdata[IEN_RAI_BIT];
    end
  end

  // Change events: detection or clearing of either condition
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prev_r <= '0;
    end else begin
      prev_r <= det;
    end
  end

  assign events = {det.aisPresent ^ prev_r.aisPresent,
                   det.raiPresent ^ prev_r.raiPresent}; // [R7]

  // Clear on read, or by writing a one; a coincident event still sets
  always_comb begin
    chg_nxt = chg_r;
    if (readClr) begin
      chg_nxt = 2'h0; // [R7]
    end
    if (wrStatus) begin
      chg_nxt[1] = chg_nxt[1] & ~hwdata[ST_AIS_CHG_BIT];
      chg_nxt[0] = chg_nxt[0] & ~hwdata[ST_RAI_CHG_BIT];
    end
    chg_nxt = chg_nxt | events; // [R7]
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chg_r <= CHG_RESET;
    end else begin
      chg_r <= chg_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |({chg_r[1] & irqEn_r[IEN_AIS_BIT],
                  chg_r[0] & irqEn_r[IEN_RAI_BIT]}); // [R8]
    end
  end

  // Read data registered in the address phase so it stands for the data phase
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hrdata_r <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      hrdata_r <= 32'h0000_0000; // [R9]
      if (regDecode(haddr[15:0]) == TCAM_REG_CFG) begin
        hrdata_r[2:0] <= cfg_r;
      end else if (regDecode(haddr[15:0]) == TCAM_REG_STATUS) begin
        hrdata_r[ST_AIS_PRES_BIT] <= det.aisPresent; // [R1]
        hrdata_r[ST_RAI_PRES_BIT] <= det.raiPresent; // [R3]
        hrdata_r[ST_AIS_CHG_BIT]  <= chg_r[1]; // [R7]
        hrdata_r[ST_RAI_CHG_BIT]  <= chg_r[0]; // [R7]
      end else if (regDecode(haddr[15:0]) == TCAM_REG_IRQEN) begin
        hrdata_r[IEN_AIS_BIT] <= irqEn_r[IEN_AIS_BIT];
        hrdata_r[IEN_RAI_BIT] <= irqEn_r[IEN_RAI_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      alarmPresent <= '0;
    end else begin
      alarmPresent <= det;
    end
  end

  // Zero-wait slave; every transfer answers OKAY
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign hrdata = hrdata_r;
  assign irq    = irq_r;

endmodule : tcam_alarm_monitor
`default_nettype wire

// File: rtl/tcam_pkg.sv
package tcam_pkg;

  // Printed offsets are register indices; the byte address is four times the index
  localparam logic [15:0] CFG_IDX        = 16'h011C;
  localparam logic [15:0] STATUS_IDX     = 16'h0B41;
  localparam logic [15:0] IRQEN_IDX      = 16'h0B42;
  localparam logic [15:0] CFG_ADDR       = {CFG_IDX[13:0], 2'b00};
  localparam logic [15:0] STATUS_ADDR    = {STATUS_IDX[13:0], 2'b00};
  localparam logic [15:0] IRQEN_ADDR     = {IRQEN_IDX[13:0], 2'b00};

  localparam int          CFG_AIS_EN_BIT  = 0;
  localparam int          CFG_RAI_EN_BIT  = 1;
  localparam int          CFG_ESF_BIT     = 2;
  localparam int          ST_AIS_PRES_BIT = 5;
  localparam int          ST_RAI_PRES_BIT = 4;
  localparam int          ST_AIS_CHG_BIT  = 1;
  localparam int          ST_RAI_CHG_BIT  = 0;
  localparam int          IEN_AIS_BIT     = 1;
  localparam int          IEN_RAI_BIT     = 0;
  localparam logic [7:0]  CFG_RESET       = 8'h00;
  localparam logic [7:0]  IRQEN_RESET     = 8'h00;
  localparam logic [1:0]  CHG_RESET       = 2'h0;
  localparam logic [2:0]  CFG_MASK        = 3'h7;

  // Signatures as 16-bit words, first received bit in bit 0
  localparam logic [15:0] AIS_SIGNATURE   = 16'h7CFF;
  localparam logic [15:0] RAI_MESSAGE     = 16'h00FF;
  localparam logic [15:0] RAI_SIGNATURE   = 16'h3EFF;
  localparam int unsigned AIS_PERIOD_BITS = 386;
  localparam int unsigned AIS_SIG_ZEROS   = 3;
  localparam int unsigned AIS_DECLARE_PER = 2;

  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned RAI_PERIOD_MS   = 1080;
  localparam int unsigned RAI_MSG_MS      = 990;
  localparam int unsigned RAI_BURST_MS    = 90;
  localparam int unsigned RAI_PERIOD_CYC  = CLK_HZ / 1000 * RAI_PERIOD_MS;
  localparam int unsigned RAI_BURST_CYC   = CLK_HZ / 1000 * RAI_BURST_MS;
  localparam int unsigned RAI_LOSS_CYC    = RAI_PERIOD_CYC + RAI_BURST_CYC;
  localparam int unsigned RAI_TMR_W       = 25;

  localparam logic [2:0]  HSIZE_WORD      = 3'h2;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;

  typedef struct packed {
    logic aisPresent;
    logic raiPresent;
  } tcam_alarm_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        write;
    logic        valid;
  } tcam_req_t;

endpackage : tcam_pkg

// File: rtl/tcam_rai_detect.sv
`timescale 1ns/1ns
`default_nettype none
module tcam_rai_detect #(
  parameter int unsigned LOSS_CYC = tcam_pkg::RAI_LOSS_CYC
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic fdlBit,
  input  wire logic fdlBitEn,
  output var  logic present
);
  import tcam_pkg::*;

  localparam logic [RAI_TMR_W-1:0] LOSS = LOSS_CYC[RAI_TMR_W-1:0];

  logic [15:0]          shift_r;
  logic                 raiSeen_r;
  logic [RAI_TMR_W-1:0] tmr_r;
  logic [15:0]          shift_nxt;

  assign shift_nxt = {fdlBit, shift_r[15:1]};

  always_ff @(posedge sys_clk) begin
    if (rst || !enable) begin
      shift_r   <= 16'h0000;
      raiSeen_r <= 1'b0;
      tmr_r     <= '0;
      present   <= 1'b0; // [R6]
    end else begin
      if (fdlBitEn) begin
        shift_r <= shift_nxt;
      end
      if (fdlBitEn && shift_nxt == RAI_MESSAGE) begin
        raiSeen_r <= 1'b1; // [R4]
      end
      // A signature burst only counts when ordinary remote alarm preceded it
      if (fdlBitEn && shift_nxt == RAI_SIGNATURE && raiSeen_r) begin // [R5]
        present   <= 1'b1;
        raiSeen_r <= 1'b0;
        tmr_r     <= '0;
      end else if (present) begin
        if (tmr_r >= LOSS) begin
          present <= 1'b0; // [R9]
        end else begin
          tmr_r <= tmr_r + {{(RAI_TMR_W-1){1'b0}}, 1'b1}; // [R4]
        end
      end
    end
  end

endmodule : tcam_rai_detect
`default_nettype wire
